// File: design/itd_pkg.sv
// Constants shared by the terminal function decoder and its input filter.
// Assumes a single 100 MHz system clock and one active-high reset.
package itd_pkg;
  localparam int NUM_TERM = 7;
  localparam int FUNC_W   = 7;
  localparam int HIT_W    = 32;
  // Function codes
  localparam logic [6:0] FN_NONE      = 7'h00;
  localparam logic [6:0] FN_RUN_AHEAD = 7'h01;
  localparam logic [6:0] FN_RUN_BACK  = 7'h02;
  localparam logic [6:0] FN_THREE_W   = 7'h03;
  localparam logic [6:0] FN_JOG_AHEAD = 7'h04;
  localparam logic [6:0] FN_JOG_BACK  = 7'h05;
  localparam logic [6:0] FN_COAST     = 7'h06;
  localparam logic [6:0] FN_RESET     = 7'h07;
  localparam logic [6:0] FN_FAULT_NO  = 7'h08;
  localparam logic [6:0] FN_FAULT_NC  = 7'h09;
  localparam logic [6:0] FN_ESTOP     = 7'h0a;
  localparam logic [6:0] FN_RSVD      = 7'h0b;
  localparam logic [6:0] FN_UP        = 7'h0c;
  localparam logic [6:0] FN_DOWN      = 7'h0d;
  localparam logic [6:0] FN_UD_CLR    = 7'h0e;
  localparam logic [6:0] FN_STEP0     = 7'h0f;
  localparam logic [6:0] FN_STEP3     = 7'h12;
  localparam logic [6:0] FN_RAMP0     = 7'h13;
  localparam logic [6:0] FN_RAMP1     = 7'h14;
  localparam logic [6:0] FN_CHSEL0    = 7'h15;
  localparam logic [6:0] FN_CHSEL1    = 7'h16;
  localparam logic [6:0] FN_HOLD      = 7'h17;
  localparam logic [6:0] FN_INHIBIT   = 7'h18;
  localparam logic [6:0] FN_FORCE_PNL = 7'h19;
  localparam logic [6:0] FN_FORCE_TRM = 7'h1a;
  localparam logic [6:0] FN_FORCE_BUS = 7'h1b;
  localparam logic [6:0] FN_AUX_CLR   = 7'h1c;
  localparam logic [6:0] FN_SRC_B     = 7'h1d;
  localparam logic [6:0] FN_SRC_APB   = 7'h1e;
  localparam logic [6:0] FN_SRC_AMB   = 7'h1f;
  localparam logic [6:0] FN_MAX       = 7'h1f;
  // Run command channels
  localparam logic [1:0] CH_PANEL = 2'h0;
  localparam logic [1:0] CH_TERM  = 2'h1;
  localparam logic [1:0] CH_COMM  = 2'h2;
  // Terminal channel select codes
  localparam logic [1:0] CHSEL_KEEP = 2'h0;
  localparam logic [1:0] CHSEL_PNL  = 2'h1;
  localparam logic [1:0] CHSEL_TRM  = 2'h2;
  // Frequency given channel meaning terminal up/down
  localparam logic [3:0] FSRC_UPDOWN = 4'h2;
  // Highest auxiliary source code that is a digital setting
  localparam logic [3:0] AUX_DIG_MAX = 4'h2;
  // Frequency combination codes
  localparam logic [3:0] COMB_B   = 4'h6;
  localparam logic [3:0] COMB_APB = 4'h7;
  localparam logic [3:0] COMB_AMB = 4'h8;
  // Selected frequency source
  localparam logic [1:0] SRC_A   = 2'h0;
  localparam logic [1:0] SRC_B   = 2'h1;
  localparam logic [1:0] SRC_APB = 2'h2;
  localparam logic [1:0] SRC_AMB = 2'h3;
  // External fault display code
  localparam logic [7:0] FAULT_EXT = 8'h13;
  // Debounce sample count
  localparam logic [3:0] FILT_MIN = 4'h1;
  localparam logic [3:0] FILT_MAX = 4'ha;
  localparam logic [3:0] FILT_DEF = 4'h5;
endpackage

// File: design/itd_input_filter.sv
// One terminal input: synchroniser, polarity and debounce.
// Assumes the pin is asynchronous and the sample count is a static setting.
`timescale 1ns/1ps
`default_nettype none
module itd_input_filter (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Terminal
  input  wire logic       pin_closed,
  input  wire logic       invert,
  input  wire logic [3:0] filt_len,
  // Result
  output logic            active
);
  import itd_pkg::*;

  logic       sync1;
  logic       sync2;
  logic [3:0] cnt;
  logic [3:0] len;
  logic       level;

  // Out-of-range settings fall back to the default count
  assign len   = (filt_len < FILT_MIN || filt_len > FILT_MAX) ? FILT_DEF : filt_len;
  assign level = sync2 ^ invert;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= pin_closed;
      sync2 <= sync1;
    end
  end

  // Level must differ for len consecutive samples before it is taken
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt    <= 4'h0;
      active <= 1'b0;
    end else if (level == active) begin
      cnt <= 4'h0;
    end else if (cnt + 4'h1 >= len) begin
      cnt    <= 4'h0;
      active <= level;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: design/itd_decoder.sv
// Multi-function input terminal decoder: filtered terminals to drive commands.
// Assumes external contacts on the pins and static configuration inputs.
`timescale 1ns/1ps
`default_nettype none
module itd_decoder (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // Terminal pins, 1 = contact closed to common
  input  wire logic [6:0]           term_closed,
  // Terminal configuration
  input  wire logic [6:0]           term_func [itd_pkg::NUM_TERM],
  input  wire logic [6:0]           term_invert,
  input  wire logic [3:0]           filt_len,
  // Drive configuration and state
  input  wire logic [1:0]           run_cmd_source,
  input  wire logic [3:0]           freq_given_src,
  input  wire logic [3:0]           aux_freq_src,
  input  wire logic [3:0]           freq_combo,
  input  wire logic                 drive_running,
  // Run commands
  output logic                      forward_run,
  output logic                      reverse_run,
  output logic                      forward_jog,
  output logic                      reverse_jog,
  output logic                      three_wire_in,
  // Stop and fault
  output logic                      coast_stop_req,
  output logic                      estop_req,
  output logic                      start_inhibit,
  output logic                      fault_reset_pulse,
  output logic                      ext_fault_flag,
  output logic [7:0]                fault_code,
  // Frequency control
  output logic                      freq_up,
  output logic                      freq_down,
  output logic                      updown_clear,
  output logic                      freq_hold,
  output logic                      aux_clear,
  output logic [1:0]                freq_src_sel,
  output logic [3:0]                step_speed_index,
  output logic [1:0]                ramp_time_sel,
  // Command channel
  output logic [1:0]                run_channel,
  // Filtered terminal states
  output logic [6:0]                term_active
);
  import itd_pkg::*;

  logic [6:0]       filt;
  logic [HIT_W-1:0] hit;
  logic             nc_fault;
  logic             reset_prev;
  logic             fault_src;
  logic             term_ctl;
  logic [1:0]       next_channel;
  logic [1:0]       next_src;

  // One filter per terminal
  for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
    itd_input_filter u_filt (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .pin_closed (term_closed[t]),
      .invert     (term_invert[t]),
      .filt_len   (filt_len),
      .active     (filt[t])
    );
  end

  // Functions above the decoded range, code 0 and the reserved slot never hit
  always_comb begin
    hit      = '0;
    nc_fault = 1'b0;
    for (int t = 0; t < NUM_TERM; t++) begin
      if (term_func[t] <= FN_MAX && filt[t]) begin
        hit[term_func[t][4:0]] = 1'b1;
      end
      // Normally closed fault reports when its contact is not active
      if (term_func[t] == FN_FAULT_NC && !filt[t]) begin
        nc_fault = 1'b1;
      end
    end
    hit[FN_NONE[4:0]] = 1'b0;
    hit[FN_RSVD[4:0]] = 1'b0;
  end

  assign term_ctl  = (run_cmd_source == CH_TERM);
  assign fault_src = hit[FN_FAULT_NO[4:0]] || nc_fault;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      term_active <= 7'h00;
    end else begin
      term_active <= filt;
    end
  end

  // Run and jog commands
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      forward_run   <= 1'b0;
      reverse_run   <= 1'b0;
      forward_jog   <= 1'b0;
      reverse_jog   <= 1'b0;
      three_wire_in <= 1'b0;
    end else begin
      forward_run   <= hit[FN_RUN_AHEAD[4:0]] && term_ctl;
      reverse_run   <= hit[FN_RUN_BACK[4:0]] && term_ctl;
      forward_jog   <= hit[FN_JOG_AHEAD[4:0]] && term_ctl;
      reverse_jog   <= hit[FN_JOG_BACK[4:0]] && term_ctl;
      three_wire_in <= hit[FN_THREE_W[4:0]];
    end
  end

  // Stop requests; hold keeps stops working since those are separate outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      coast_stop_req <= 1'b0;
      estop_req      <= 1'b0;
      start_inhibit  <= 1'b0;
      freq_hold      <= 1'b0;
    end else begin
      coast_stop_req <= hit[FN_COAST[4:0]]
                        || (hit[FN_INHIBIT[4:0]] && drive_running);
      estop_req      <= hit[FN_ESTOP[4:0]];
      start_inhibit  <= hit[FN_INHIBIT[4:0]];
      freq_hold      <= hit[FN_HOLD[4:0]];
    end
  end

  // Reset acts on the closing edge, so a held terminal resets only once
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reset_prev        <= 1'b0;
      fault_reset_pulse <= 1'b0;
    end else begin
      reset_prev        <= hit[FN_RESET[4:0]];
      fault_reset_pulse <= hit[FN_RESET[4:0]] && !reset_prev;
    end
  end

  // Sticky external fault; a live fault source beats the reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ext_fault_flag <= 1'b0;
      fault_code     <= 8'h00;
    end else if (fault_src) begin
      ext_fault_flag <= 1'b1;
      fault_code     <= FAULT_EXT;
    end else if (fault_reset_pulse) begin
      ext_fault_flag <= 1'b0;
      fault_code     <= 8'h00;
    end
  end

  // Frequency adjustment
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      freq_up      <= 1'b0;
      freq_down    <= 1'b0;
      updown_clear <= 1'b0;
      aux_clear    <= 1'b0;
    end else begin
      freq_up      <= hit[FN_UP[4:0]] && freq_given_src == FSRC_UPDOWN;
      freq_down    <= hit[FN_DOWN[4:0]] && freq_given_src == FSRC_UPDOWN;
      updown_clear <= hit[FN_UD_CLR[4:0]];
      aux_clear    <= hit[FN_AUX_CLR[4:0]] && aux_freq_src <= AUX_DIG_MAX;
    end
  end

  // Step speed and ramp pair indexes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      step_speed_index <= 4'h0;
      ramp_time_sel    <= 2'h0;
    end else begin
      step_speed_index <= hit[FN_STEP3[4:0]:FN_STEP0[4:0]];
      ramp_time_sel    <= {hit[FN_RAMP1[4:0]], hit[FN_RAMP0[4:0]]};
    end
  end

  // Forcing outranks the select pair; panel beats terminal beats comms
  always_comb begin
    case ({hit[FN_CHSEL1[4:0]], hit[FN_CHSEL0[4:0]]})
      CHSEL_KEEP: next_channel = run_cmd_source;
      CHSEL_PNL:  next_channel = CH_PANEL;
      CHSEL_TRM:  next_channel = CH_TERM;
      default:    next_channel = CH_COMM;
    endcase
    if (hit[FN_FORCE_PNL[4:0]]) begin
      next_channel = CH_PANEL;
    end else if (hit[FN_FORCE_TRM[4:0]]) begin
      next_channel = CH_TERM;
    end else if (hit[FN_FORCE_BUS[4:0]]) begin
      next_channel = CH_COMM;
    end
  end

  // Source switches only when the combination setting matches
  always_comb begin
    next_src = SRC_A;
    case (freq_combo)
      COMB_B: begin
        if (hit[FN_SRC_B[4:0]]) next_src = SRC_B;
      end
      COMB_APB: begin
        if (hit[FN_SRC_APB[4:0]]) next_src = SRC_APB;
      end
      COMB_AMB: begin
        if (hit[FN_SRC_AMB[4:0]]) next_src = SRC_AMB;
      end
      default: next_src = SRC_A;
    endcase
  end

  // No stored prior channel: it is recomputed, so release restores it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      run_channel  <= CH_PANEL;
      freq_src_sel <= SRC_A;
    end else begin
      run_channel  <= next_channel;
      freq_src_sel <= next_src;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_forward_gate: assert property (
    forward_run |-> $past(hit[FN_RUN_AHEAD[4:0]]) && $past(run_cmd_source) == CH_TERM)
    else $error("forward run without terminal control");
  a_reverse_gate: assert property (
    $past(hit[FN_RUN_BACK[4:0]]) && $past(run_cmd_source) != CH_TERM |-> !reverse_run)
    else $error("reverse run outside terminal control");
  a_three_wire: assert property (
    $rose(hit[FN_THREE_W[4:0]]) |=> three_wire_in)
    else $error("three-wire input not followed");
  a_forward_jog: assert property (
    hit[FN_JOG_AHEAD[4:0]] && term_ctl |=> forward_jog)
    else $error("forward jog missed");
  a_reverse_jog: assert property (
    reverse_jog |-> $past(term_ctl) && $past(hit[FN_JOG_BACK[4:0]]))
    else $error("reverse jog without cause");
  a_coast_req: assert property (
    hit[FN_COAST[4:0]] |=> coast_stop_req)
    else $error("coast stop not requested");
  a_reset_edge: assert property (
    fault_reset_pulse |=> !fault_reset_pulse)
    else $error("fault reset longer than one cycle");
  a_reset_clear: assert property (
    fault_reset_pulse && !fault_src |=> !ext_fault_flag)
    else $error("fault not cleared by reset");
  a_fault_code: assert property (
    fault_src |=> ext_fault_flag && fault_code == FAULT_EXT)
    else $error("external fault not flagged");
  a_estop_req: assert property (
    estop_req == $past(hit[FN_ESTOP[4:0]]))
    else $error("emergency stop mismatch");
  a_updown_gate: assert property (
    (freq_up || freq_down) |-> $past(freq_given_src) == FSRC_UPDOWN)
    else $error("up/down outside up/down source");
  a_updown_clr: assert property (
    hit[FN_UD_CLR[4:0]] |=> updown_clear)
    else $error("up/down clear missed");
  a_step_index: assert property (
    ##1 step_speed_index == $past(hit[FN_STEP3[4:0]:FN_STEP0[4:0]]))
    else $error("step index wrong");
  a_ramp_pair: assert property (
    !hit[FN_RAMP0[4:0]] && !hit[FN_RAMP1[4:0]] |=> ramp_time_sel == 2'h0)
    else $error("ramp pair not 1");
  a_chan_sel: assert property (
    hit[FN_CHSEL1[4:0]] && hit[FN_CHSEL0[4:0]] && hit[FN_FORCE_BUS[4:0] -: 3] == 3'h0
    |=> run_channel == CH_COMM)
    else $error("channel select to comms failed");
  a_hold: assert property (
    hit[FN_HOLD[4:0]] && hit[FN_COAST[4:0]] |=> freq_hold && coast_stop_req)
    else $error("stop lost during hold");
  a_inhibit: assert property (
    hit[FN_INHIBIT[4:0]] && drive_running |=> coast_stop_req && start_inhibit)
    else $error("inhibit not applied");
  a_force_pnl: assert property (
    hit[FN_FORCE_PNL[4:0]] |=> run_channel == CH_PANEL)
    else $error("panel force failed");
  a_aux_clear: assert property (
    aux_clear |-> $past(aux_freq_src) <= AUX_DIG_MAX)
    else $error("aux clear on non-digital source");
  a_src_b: assert property (
    freq_combo == COMB_B && hit[FN_SRC_B[4:0]] |=> freq_src_sel == SRC_B)
    else $error("source B not selected");
  a_src_apb: assert property (
    freq_src_sel == SRC_APB |-> $past(freq_combo) == COMB_APB)
    else $error("A+B without combination 7");
  a_src_amb: assert property (
    freq_src_sel == SRC_AMB |-> $past(hit[FN_SRC_AMB[4:0]]))
    else $error("A-B without terminal");
  a_reserved: assert property (
    !hit[FN_RSVD[4:0]] && !hit[FN_NONE[4:0]])
    else $error("reserved function decoded");
  a_fault_sticky: assert property (
    ext_fault_flag && !fault_reset_pulse |=> ext_fault_flag)
    else $error("external fault dropped without reset");
  a_nc_fault: assert property (
    nc_fault |=> ext_fault_flag)
    else $error("open fault contact not flagged");
  a_chan_keep: assert property (
    hit[FN_CHSEL1[4:0]:FN_CHSEL0[4:0]] == 2'h0 && hit[FN_FORCE_BUS[4:0] -: 3] == 3'h0
    |=> run_channel == $past(run_cmd_source))
    else $error("configured channel not kept");
  a_ramp_index: assert property (
    ##1 ramp_time_sel == $past({hit[FN_RAMP1[4:0]], hit[FN_RAMP0[4:0]]}))
    else $error("ramp pair index wrong");
  a_inhibit_idle: assert property (
    hit[FN_INHIBIT[4:0]] && !drive_running && !hit[FN_COAST[4:0]]
    |=> start_inhibit && !coast_stop_req)
    else $error("inhibit wrong in standby");
  a_term_active: assert property (
    ##1 term_active == $past(filt))
    else $error("filtered terminal state wrong");
endmodule
`default_nettype wire

// File: test/itd_contacts.sv
// External contacts on the seven input terminals, with contact chatter.
// Assumes the bench changes the wanted contact state off the rising edge.
`timescale 1ns/1ps
`default_nettype none
module itd_contacts (
  // Clock
  input  wire logic       sys_clk,
  // Wanted contact state and chatter length in cycles
  input  wire logic [6:0] want,
  input  wire logic [3:0] bounce,
  // Pins, 1 = shorted to common
  output logic [6:0]      term_closed
);
  logic [6:0] last;
  logic [3:0] cnt [7];
  initial begin
    term_closed = 7'h00;
    last = 7'h00;
    for (int i = 0; i < 7; i++) cnt[i] = 4'h0;
  end
  // Chatter toggles every cycle, so no run of equal samples can fool a long filter
  always @(posedge sys_clk) begin
    for (int i = 0; i < 7; i++) begin
      if (want[i] !== last[i]) begin
        last[i] <= want[i];
        cnt[i] <= bounce;
        term_closed[i] <= ~term_closed[i];
      end else if (cnt[i] != 4'h0) begin
        cnt[i] <= cnt[i] - 4'h1;
        term_closed[i] <= ~term_closed[i];
      end else begin
        term_closed[i] <= last[i];
      end
    end
  end
endmodule
`default_nettype wire

// File: test/inverter_terminal_function_decoder_tb.sv
// Self-checking bench for the terminal function decoder.
// Assumes contacts modelled by itd_contacts and static configuration inputs.
`timescale 1ns/1ps
`default_nettype none
module inverter_terminal_function_decoder_tb;
  import itd_pkg::*;
  logic       sys_clk, rst, drive_running;
  logic [6:0] want, term_closed, term_invert, term_active;
  logic [6:0] term_func [NUM_TERM];
  logic [3:0] bounce, filt_len, freq_given_src, aux_freq_src, freq_combo, step_speed_index;
  logic [1:0] run_cmd_source, freq_src_sel, ramp_time_sel, run_channel;
  logic       forward_run, reverse_run, forward_jog, reverse_jog, three_wire_in;
  logic       coast_stop_req, estop_req, start_inhibit, fault_reset_pulse, ext_fault_flag;
  logic       freq_up, freq_down, updown_clear, freq_hold, aux_clear;
  logic [3:0] runs;
  logic [7:0] fault_code;
  logic [8:0] lv;
  int         error_cnt, n_compared, pulses, lows;
  logic [8:0] exp_lv [11] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h008, 9'h004,
                              9'h002, 9'h001, 9'h000, 9'h000};
  logic [6:0] codes [11] = '{7'h03, 7'h06, 7'h0a, 7'h18, 7'h17, 7'h0c, 7'h0d, 7'h0e,
                             7'h1c, 7'h00, 7'h0b};
  logic [1:0] exp_ch [4] = '{2'h2, 2'h0, 2'h1, 2'h2};
  assign lv = {three_wire_in, coast_stop_req, estop_req, start_inhibit, freq_hold, freq_up,
               freq_down, updown_clear, aux_clear};
  assign runs = {forward_run, reverse_run, forward_jog, reverse_jog};
  itd_contacts i_contacts (.sys_clk(sys_clk), .want(want), .bounce(bounce),
                           .term_closed(term_closed));
  itd_decoder i_dut (.sys_clk(sys_clk), .rst(rst), .term_closed(term_closed),
    .term_func(term_func), .term_invert(term_invert), .filt_len(filt_len),
    .run_cmd_source(run_cmd_source), .freq_given_src(freq_given_src),
    .aux_freq_src(aux_freq_src), .freq_combo(freq_combo), .drive_running(drive_running),
    .forward_run(forward_run), .reverse_run(reverse_run), .forward_jog(forward_jog),
    .reverse_jog(reverse_jog),
    .three_wire_in(three_wire_in), .coast_stop_req(coast_stop_req), .estop_req(estop_req),
    .start_inhibit(start_inhibit), .fault_reset_pulse(fault_reset_pulse),
    .ext_fault_flag(ext_fault_flag), .fault_code(fault_code), .freq_up(freq_up),
    .freq_down(freq_down), .updown_clear(updown_clear), .freq_hold(freq_hold),
    .aux_clear(aux_clear), .freq_src_sel(freq_src_sel), .step_speed_index(step_speed_index),
    .ramp_time_sel(ramp_time_sel), .run_channel(run_channel), .term_active(term_active));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Long enough for chatter, two sync stages, ten filter samples and the output stage
  task automatic settle();
    pulses = 0;
    repeat (20) begin
      @(negedge sys_clk);
      if (fault_reset_pulse === 1'b1) pulses++;
    end
  endtask
  task automatic clear_all();
    want = 7'h00;
    for (int i = 0; i < NUM_TERM; i++) term_func[i] = FN_NONE;
    settle();
  endtask
  task automatic single(input logic [6:0] code, input logic [8:0] exp);
    term_func[0] = code;
    want[0] = 1'b1;
    settle();
    check("levels", lv, exp);
    want[0] = 1'b0;
    settle();
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100us;
    error_cnt++;
    end_sim();
  end
  initial begin
    error_cnt = 0;
    n_compared = 0;
    rst = 1'b1;
    want = 7'h00;
    bounce = 4'h0;
    term_invert = 7'h00;
    filt_len = 4'h1;
    run_cmd_source = 2'h1;
    freq_given_src = FSRC_UPDOWN;
    aux_freq_src = 4'h0;
    freq_combo = 4'h0;
    drive_running = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) term_func[i] = FN_NONE;
    repeat (8) @(negedge sys_clk);
    check("reset channel", {7'h00, run_channel}, 9'h000);
    rst = 1'b0;
    term_func[0:3] = '{FN_RUN_AHEAD, FN_RUN_BACK, FN_JOG_AHEAD, FN_JOG_BACK};
    want = 7'h0f;
    settle();
    check("run set", {5'h00, runs}, 9'h00f);
    run_cmd_source = 2'h0;
    settle();
    check("run gated", {5'h00, runs}, 9'h000);
    clear_all();
    for (int k = 0; k < 11; k++) single(codes[k], exp_lv[k]);
    freq_given_src = 4'h3;
    single(FN_UP, 9'h000);
    aux_freq_src = 4'h3;
    single(FN_AUX_CLR, 9'h000);
    drive_running = 1'b1;
    single(FN_INHIBIT, 9'h0a0);
    term_func[0:5] = '{FN_STEP0, 7'h10, 7'h11, FN_STEP3, FN_RAMP0, FN_RAMP1};
    for (int i = 0; i < 16; i++) begin
      want = {1'b0, i[1:0], i[3:0]};
      settle();
      check("step", {5'h00, step_speed_index}, i[8:0]);
      check("ramp", {7'h00, ramp_time_sel}, {7'h00, i[1:0]});
    end
    clear_all();
    run_cmd_source = 2'h2;
    term_func[0:4] = '{FN_CHSEL0, FN_CHSEL1, FN_FORCE_PNL, FN_FORCE_TRM, FN_FORCE_BUS};
    for (int i = 0; i < 4; i++) begin
      want = {5'h00, i[1:0]};
      settle();
      check("channel", {7'h00, run_channel}, {7'h00, exp_ch[i]});
    end
    want = 7'h1d;
    settle();
    check("force order", {7'h00, run_channel}, 9'h000);
    want = 7'h19;
    settle();
    check("force term", {7'h00, run_channel}, 9'h001);
    want = 7'h11;
    settle();
    check("force comm", {7'h00, run_channel}, 9'h002);
    want = 7'h01;
    settle();
    check("force restore", {7'h00, run_channel}, 9'h000);
    clear_all();
    term_func[0:2] = '{FN_SRC_B, FN_SRC_APB, FN_SRC_AMB};
    for (int k = 0; k < 3; k++) begin
      freq_combo = COMB_B + 4'(k);
      want = 7'h01 << k;
      settle();
      check("source", {7'h00, freq_src_sel}, 9'(k + 1));
      want = 7'h01 << ((k + 1) % 3);
      settle();
      check("source other", {7'h00, freq_src_sel}, 9'h000);
    end
    clear_all();
    // Close the fault contact before it gets its function, else the open contact flags at once
    want = 7'h04;
    settle();
    term_func[0:2] = '{FN_FAULT_NO, FN_RESET, FN_FAULT_NC};
    settle();
    check("fault none", {ext_fault_flag, fault_code}, 9'h000);
    want = 7'h05;
    settle();
    want = 7'h04;
    settle();
    check("fault sticky", {ext_fault_flag, fault_code}, 9'h113);
    run_cmd_source = 2'h0;
    want = 7'h06;
    settle();
    check("reset pulses", 9'(pulses), 9'h001);
    check("fault cleared", {ext_fault_flag, fault_code}, 9'h000);
    want = 7'h00;
    settle();
    check("fault nc", {ext_fault_flag, fault_code}, 9'h113);
    rst = 1'b1;
    @(negedge sys_clk);
    check("mid reset", {ext_fault_flag, fault_code}, 9'h000);
    rst = 1'b0;
    clear_all();
    term_func[0:1] = '{FN_COAST, FN_COAST};
    term_invert = 7'h01;
    settle();
    check("inverted", {coast_stop_req, term_active}, 9'h081);
    want = 7'h03;
    settle();
    check("or shared", {coast_stop_req, term_active}, 9'h082);
    term_invert = 7'h00;
    term_func[0] = FN_ESTOP;
    want = 7'h00;
    filt_len = 4'h5;
    bounce = 4'h3;
    settle();
    want = 7'h01;
    settle();
    check("debounced", {8'h00, estop_req}, 9'h001);
    bounce = 4'h0;
    want = 7'h00;
    repeat (3) @(negedge sys_clk);
    want = 7'h01;
    // A three-sample dip must never reach the output while it passes the filter
    lows = 0;
    repeat (20) begin
      @(negedge sys_clk);
      if (estop_req !== 1'b1) lows++;
    end
    check("glitch", 9'(lows), 9'h000);
    check("glitch end", {8'h00, estop_req}, 9'h001);
    end_sim();
  end
endmodule
`default_nettype wire
